// ---- iso_readback_pkg.sv ----
// Constants and carrier types for the isochronous read-back port.
// Assumes one system clock shared with the host bus command logic.
package iso_readback_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0]  CMD_ISO0_COUNT_RD = 8'h2D;
	localparam logic [7:0]  CMD_ISO1_COUNT_RD = 8'h2E;
	localparam logic [7:0]  CMD_ISO_PORT_RD   = 8'h40;
	localparam logic [7:0]  CMD_ISO_PORT_WR   = 8'hC0;

	// ----------------------------------------
	// Sizes, steps and reset values
	// ----------------------------------------
	localparam int          RAM_WORDS         = 2048;
	localparam int          WORD_ADDR_BITS    = 11;
	localparam logic [15:0] PTR_STEP          = 16'h0002;
	localparam logic [15:0] COUNT_RESET       = 16'h0000;
	localparam logic [15:0] PTR_RESET         = 16'h0000;
	localparam logic [15:0] DATA_RESET        = 16'h0000;
	localparam int          EVEN_LANE_MSB     = 15;
	localparam int          EVEN_LANE_LSB     = 8;
	localparam int          ODD_LANE_MSB      = 7;
	localparam int          ODD_LANE_LSB      = 0;

	// ----------------------------------------
	// Host bus request carrier
	// ----------------------------------------
	typedef struct packed {
		logic        cmd_wr;
		logic        data_rd;
		logic        data_wr;
		logic [15:0] data;
	} host_req_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_COUNT0,
		ST_COUNT1,
		ST_PORT_RD,
		ST_PORT_WR,
		ST_PORT_DONE
	} port_state_t;

endpackage

// ---- iso_buffer_readback_port.sv ----
// Read-back count registers and isochronous buffer RAM data port.
// Assumes host bus strobes are synchronous one-cycle pulses on clk_sys_in.
// Contract
// - Command 2D reads buffer zero pending bytes
// - Command 2E reads buffer one pending bytes
// - 16-bit port: 40 reads, C0 writes
// - Upper byte lane holds even address
// - Lower byte lane holds odd address
// - Counts 16-bit read-only, zero at reset
// - Pointer advances two bytes per word
// - Pointer reaching count raises end event
`timescale 1ns/1ps
`default_nettype none

module iso_buffer_readback_port
	import iso_readback_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire host_req_t   host_req_in,
	input  wire logic [15:0] iso0_pending_bytes_in,
	input  wire logic [15:0] iso1_pending_bytes_in,
	input  wire logic [15:0] transfer_byte_counter_in,
	input  wire logic [15:0] iso_buffer_base_in,
	output logic      [15:0] port_word_out,
	output logic             transfer_end_out
);

	// ----------------------------------------
	// Byte address to word index
	// ----------------------------------------
	function automatic logic [WORD_ADDR_BITS-1:0] word_index(
		input logic [15:0] base,
		input logic [15:0] ptr
	);
		logic [15:0] sum;
		sum = base + ptr;
		return sum[WORD_ADDR_BITS:1];
	endfunction

	// ----------------------------------------
	// Buffer storage
	// ----------------------------------------
	logic [15:0]              ram [0:RAM_WORDS-1];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0]              iso0_readback_byte_count;
	logic [15:0]              iso1_readback_byte_count;
	logic [15:0]              ptr;
	logic [15:0]              xfer_count;
	port_state_t              state;

	// ----------------------------------------
	// Next values and decode wires
	// ----------------------------------------
	port_state_t              next_state;
	logic [15:0]              next_ptr;
	logic [15:0]              next_word;
	logic [15:0]              first_word;
	logic [15:0]              code_word;
	logic [7:0]               code;
	logic                     step;
	logic                     reach;
	logic [WORD_ADDR_BITS-1:0] cur_idx;
	logic                     cmd_strobe;
	logic                     rd_strobe;
	logic                     wr_strobe;
	logic                     port_rd_hit;
	logic                     port_wr_hit;
	logic                     end_event;

	// ----------------------------------------
	// Host bus fields
	// ----------------------------------------
	assign cmd_strobe = host_req_in.cmd_wr;
	assign rd_strobe  = host_req_in.data_rd;
	assign wr_strobe  = host_req_in.data_wr;
	assign code       = host_req_in.data[7:0];

	// ----------------------------------------
	// Pointer arithmetic
	// ----------------------------------------
	assign next_ptr   = ptr + PTR_STEP;
	assign reach      = next_ptr >= xfer_count;
	assign cur_idx    = word_index(iso_buffer_base_in, ptr);
	assign next_word  = ram[word_index(iso_buffer_base_in, next_ptr)];
	assign first_word = ram[word_index(iso_buffer_base_in, PTR_RESET)];

	// ----------------------------------------
	// Transfer strobes
	// ----------------------------------------
	assign step        = (state == ST_PORT_RD && rd_strobe) || (state == ST_PORT_WR && wr_strobe);
	assign port_rd_hit = !cmd_strobe && state == ST_PORT_RD && rd_strobe;
	assign port_wr_hit = !cmd_strobe && state == ST_PORT_WR && wr_strobe;
	assign end_event   = (port_rd_hit || port_wr_hit) && reach;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_state = state;
		code_word  = DATA_RESET;
		if (host_req_in.cmd_wr) begin
			case (code)
				CMD_ISO0_COUNT_RD: begin
					next_state = ST_COUNT0;
					code_word  = iso0_readback_byte_count;
				end
				CMD_ISO1_COUNT_RD: begin
					next_state = ST_COUNT1;
					code_word  = iso1_readback_byte_count;
				end
				CMD_ISO_PORT_RD: begin
					next_state = (transfer_byte_counter_in == COUNT_RESET)
					           ? ST_PORT_DONE : ST_PORT_RD;
					code_word  = first_word;
				end
				CMD_ISO_PORT_WR: begin
					next_state = (transfer_byte_counter_in == COUNT_RESET)
					           ? ST_PORT_DONE : ST_PORT_WR;
				end
				default: begin
					next_state = ST_IDLE;
				end
			endcase
		end else if (step && reach) begin
			next_state = ST_PORT_DONE;
		end
	end

	// ----------------------------------------
	// Count registers, writes never reach them
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			iso0_readback_byte_count <= COUNT_RESET;
			iso1_readback_byte_count <= COUNT_RESET;
		end else begin
			iso0_readback_byte_count <= iso0_pending_bytes_in;
			iso1_readback_byte_count <= iso1_pending_bytes_in;
		end
	end

	// ----------------------------------------
	// Port sequencing
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state            <= ST_IDLE;
			transfer_end_out <= 1'b0;
		end else begin
			state            <= next_state;
			transfer_end_out <= end_event;
		end
	end

	// ----------------------------------------
	// Pointer and captured count
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ptr        <= PTR_RESET;
			xfer_count <= COUNT_RESET;
		end else if (cmd_strobe) begin
			ptr        <= PTR_RESET;
			xfer_count <= transfer_byte_counter_in;
		end else if (step) begin
			ptr <= next_ptr;
		end
	end

	// ----------------------------------------
	// Buffer RAM write, even byte in upper lane
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (port_wr_hit) begin
			ram[cur_idx][EVEN_LANE_MSB:EVEN_LANE_LSB] <=
				host_req_in.data[EVEN_LANE_MSB:EVEN_LANE_LSB];
			ram[cur_idx][ODD_LANE_MSB:ODD_LANE_LSB] <=
				host_req_in.data[ODD_LANE_MSB:ODD_LANE_LSB];
		end
	end

	// ----------------------------------------
	// Read data word
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			port_word_out <= DATA_RESET;
		end else if (host_req_in.cmd_wr) begin
			port_word_out <= code_word;
		end else begin
			case (state)
				ST_COUNT0: begin
					port_word_out <= iso0_readback_byte_count;
				end
				ST_COUNT1: begin
					port_word_out <= iso1_readback_byte_count;
				end
				ST_PORT_RD: begin
					if (host_req_in.data_rd) begin
						port_word_out <= reach ? DATA_RESET : next_word;
					end
				end
				ST_PORT_DONE: begin
					port_word_out <= DATA_RESET;
				end
				default: begin
					port_word_out <= port_word_out;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- iso_host_model.sv ----
// Host-side transfer byte counter model.
// Assumes the bench writes the count it read back.
`timescale 1ns/1ps
`default_nettype none
module iso_host_model (
	input  wire logic [15:0] value_in,
	output logic      [15:0] count_out
);
	assign count_out = value_in;
endmodule
`default_nettype wire

// ---- iso_readback_chk.sv ----
// Pin-level assertions for the read-back port.
// Assumes binding onto the top module.
`timescale 1ns/1ps
`default_nettype none
module iso_readback_chk
	import iso_readback_pkg::*;
(
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	input wire host_req_t   host_req_in,
	input wire logic [15:0] iso0_pending_bytes_in,
	input wire logic [15:0] iso1_pending_bytes_in,
	input wire logic [15:0] transfer_byte_counter_in,
	input wire logic [15:0] port_word_out,
	input wire logic        transfer_end_out
);
	wire logic       cw = host_req_in.cmd_wr;
	wire logic [7:0] k  = host_req_in.data[7:0];
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	sequence s_port(n); cw && (k == 8'h40 || k == 8'hC0) && transfer_byte_counter_in == n; endsequence
	sequence s_strb; !cw && (host_req_in.data_rd || host_req_in.data_wr); endsequence
	property p_c0; cw && k == 8'h2D |=> port_word_out == $past(iso0_pending_bytes_in, 2); endproperty
	a_c0: assert property (p_c0) else $error("count zero");
	property p_c1; cw && k == 8'h2E |=> port_word_out == $past(iso1_pending_bytes_in, 2); endproperty
	a_c1: assert property (p_c1) else $error("count one");
	property p_bad; cw && k == 8'h00 |=> port_word_out == 16'h0000; endproperty
	a_bad: assert property (p_bad) else $error("bad code");
	property p_pulse; transfer_end_out |=> !transfer_end_out; endproperty
	a_pulse: assert property (p_pulse) else $error("end width");
	property p_cause; transfer_end_out |-> $past(host_req_in.data_rd) || $past(host_req_in.data_wr);
	endproperty
	a_cause: assert property (p_cause) else $error("end cause");
	property p_end2; s_port(16'h0002) ##1 s_strb |=> transfer_end_out; endproperty
	a_end2: assert property (p_end2) else $error("end late");
	property p_step; s_port(16'h0004) ##1 s_strb |=> !transfer_end_out; endproperty
	a_step: assert property (p_step) else $error("end early");
	property p_rz; transfer_end_out && $past(host_req_in.data_rd) |-> port_word_out == 16'h0000;
	endproperty
	a_rz: assert property (p_rz) else $error("end word");
endmodule
`default_nettype wire

// ---- iso_buffer_readback_port_test.sv ----
// Bench driving host bus command and data cycles.
// Assumes the host model mirrors the loaded byte count.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module iso_buffer_readback_port_test import iso_readback_pkg::*;;
	logic      clk_sys_in = 1'h0, rst_in = 1'h1, te;
	logic [15:0] lv = 16'h0000, cnt, w;
	host_req_t req = '0;
	int        bad_count = 0, comparisons = 0;
	always #2.5 clk_sys_in = ~clk_sys_in;
	iso_host_model HOST (.value_in(lv), .count_out(cnt));
	iso_buffer_readback_port DUT (.clk_sys_in, .rst_in, .host_req_in(req),
		.iso0_pending_bytes_in(16'h0004), .iso1_pending_bytes_in(16'h0006),
		.transfer_byte_counter_in(cnt), .iso_buffer_base_in(16'h0000),
		.port_word_out(w), .transfer_end_out(te));
	task put(input logic [2:0] s, input logic [15:0] d);
		@(posedge clk_sys_in) #1 req = {s, d};
	endtask
	task stop_test;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#5000 bad_count++;
		stop_test;
	end
	initial begin
		#8.5 rst_in = 1'h0;
		`CHK("w", 16'h0000, w)
		put(3'h4, 16'h002D);
		put(3'h1, 16'hFFFF);
		`CHK("c0", 16'h0004, w)
		put(3'h4, 16'h002E);
		`CHK("ro", 16'h0004, w)
		put(3'h4, 16'h0000);
		`CHK("c1", 16'h0006, w)
		lv = 16'h0004;
		put(3'h4, 16'h00C0);
		put(3'h1, 16'hA1B2);
		put(3'h1, 16'hC3D4);
		put(3'h0, 16'h0000);
		`CHK("we", 1'h1, te)
		put(3'h4, 16'h0040);
		put(3'h2, 16'h0000);
		`CHK("r0", 16'hA1B2, w)
		put(3'h2, 16'h0000);
		`CHK("r1", 16'hC3D4, w)
		put(3'h0, 16'h0000);
		`CHK("re", 1'h1, te)
		lv = 16'h0002;
		put(3'h4, 16'h00C0);
		put(3'h1, 16'h5A5A);
		put(3'h0, 16'h0000);
		`CHK("w2", 1'h1, te)
		put(3'h0, 16'h0000);
		stop_test;
	end
endmodule
bind iso_buffer_readback_port iso_readback_chk CHECK (.*);
`default_nettype wire
